// ---- dv/dcc_cc_asserts.sv ----
`timescale 1ns/1ps
module dcc_cc_asserts
  import dcc_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic masterEnable,
  input wire logic nmiSeenFlag,
  input wire logic addressErrorFlag,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [NUM_CH-1:0] unitDone,
  input wire logic [NUM_CH-1:0] countLast,
  input wire logic [NUM_CH-1:0] transferEnabled,
  input wire logic [NUM_CH-1:0] countDecrement,
  input wire logic [NUM_CH-1:0] completionIrq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // steps of a write and of a normal completion on channel 2
  sequence awTaken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence wTaken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence lastUnit;
    unitDone[2] && countLast[2] && transferEnabled[2];
  endsequence

  a_write_answer: assert property (awTaken and wTaken |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == DCC_RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_block_enable: assert property (nmiSeenFlag || addressErrorFlag || !masterEnable |=> transferEnabled == '0)
    else $error("channel enabled while blocked");
  a_done_stops: assert property (lastUnit |-> ##2 !transferEnabled[2])
    else $error("channel runs after completion");
  a_irq_cause: assert property ($rose(completionIrq[2]) |-> $past(unitDone[2] && countLast[2]) || $past(unitDone[2] && countLast[2], 2))
    else $error("interrupt without completion");
  a_dec_cause: assert property ((countDecrement & ~$past(unitDone)) == '0)
    else $error("decrement without unit");
endmodule

bind dcc_channel_control dcc_cc_asserts #(.NUM_CH(NUM_CH)) u_chk (.*);

// ---- dv/dcc_req_model.sv ----
`timescale 1ns/1ps
module dcc_req_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] want,
  input wire logic [1:0] takenLow,
  input wire logic [1:0] requestTakenOut,
  input wire logic [3:0] evtCode,
  output logic [1:0] transferRequestIn_n,
  output logic [9:0] periphEvent
);
  logic [1:0] seen;
  assign seen = requestTakenOut ^ takenLow;
  // device pulls low until its notice shows, then the pull-up wins; events last one cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      transferRequestIn_n <= 2'h3;
    else
      transferRequestIn_n <= ~want | seen;
    periphEvent <= (evtCode >= 4'h6) ? (10'h001 << (evtCode - 4'h6)) : 10'h000;
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import dcc_pkg::*;
;
  logic clk = 1'h0, nrst = 1'h0, standby = 1'h0, masterEnable = 1'h0;
  logic nmiSeenFlag = 1'h0, addressErrorFlag = 1'h0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, srcStep, dstStep;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, srcReload;
  logic [1:0] s_axi_bresp, s_axi_rresp, transferRequestIn_n, transferAckOut, requestTakenOut;
  logic [1:0] want = '0, takenLow = '0;
  logic [3:0] evtCode = '0, unitDone = '0, countLast = '0, readCycle = '0, writeCycle = '0;
  logic [9:0] periphEvent;
  logic [3:0] transferEnabled, channelRequest, countDecrement, completionIrq, burstMode;
  logic [7:0] unitSize;
  int failures = 0, comparisons = 0, decs = 0;

  always #10 clk = ~clk;

  dcc_channel_control u_dut (.*);
  dcc_req_model u_far (.*);

  // decrements seen on the auto-request channel
  always @(posedge clk)
    if (countDecrement[2])
      decs <= decs + 1;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
      begin
        failures++;
        $display("BAD %0t saw %h wanted %h", $time, seen, exp);
      end
  endtask

  task close_out;
    $display("compares %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // both write halves go out together; each drops once taken
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ka, kw;
    ka = 1'h0;
    kw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ka && kw))
    begin
      @(posedge clk);
      ka = ka | s_axi_awready;
      kw = kw | s_axi_wready;
      s_axi_awvalid <= !ka;
      s_axi_wvalid <= !kw;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  // rready comes late on purpose so the slave must hold its answer
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task rchk(input int c, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(12'(4 * c), d, r);
    chk(d, exp);
  endtask

  task pulse(input logic [3:0] m, input logic l);
    unitDone <= m;
    countLast <= l ? m : 4'h0;
    @(posedge clk);
    unitDone <= 4'h0;
    countLast <= 4'h0;
  endtask

  task fire(input logic [3:0] code);
    evtCode <= code;
    @(posedge clk);
    evtCode <= 4'h0;
  endtask

  function automatic logic [31:0] wmask(int c);
    return DCC_MASK_COMMON | (c < 2 ? DCC_MASK_EXT : c == 2 ? DCC_MASK_CH2 : DCC_MASK_CH3);
  endfunction

  function automatic logic [7:0] stp(logic [1:0] m, logic [1:0] s);
    logic [7:0] d;
    d = s == 2'h0 ? 8'h01 : s == 2'h1 ? 8'h02 : s == 2'h2 ? 8'h04 : 8'h00;
    return m == 2'h1 ? d : m == 2'h2 ? -d : 8'h00;
  endfunction

  initial
  begin
    logic [31:0] d, v;
    logic [1:0] r;
    int c, n;
    void'($urandom(32'h086880bb));
    tick(8);
    nrst <= 1'h1;
    for (c = 0; c < 4; c++) rchk(c, DCC_CTRL_RESET);
    rd(12'h010, d, r);
    chk(r, DCC_RESP_SLVERR);
    chk(d, 32'h00000000);
    wr(12'h002, 32'hFFFFFFFF, r);
    chk(r, DCC_RESP_SLVERR);
    // all ones: absent fields stay zero and the flag cannot be set
    for (c = 0; c < 4; c++)
    begin
      wr(12'(4 * c), 32'hFFFFFFFF, r);
      rchk(c, wmask(c));
    end
    // master enable still off: pins sit at their inverted idle level, ch2 reload bit set
    chk({srcReload, transferAckOut, requestTakenOut}, 5'h1F);
    $display("register map done");
    for (n = 0; n < 24; n++)
    begin
      c = n < 2 ? n : $urandom_range(3);
      v = $urandom & wmask(c) & 32'hFFFFFFFE;
      if (n < 2 || (c > 1 && v[11:8] == 4'h3))
        v[11:8] = n < 2 ? 4'h3 : 4'h4;
      wr(12'(4 * c), v, r);
      rchk(c, v);
      d = (c == 3 && v[20]) ? 32'h2 : v[4:3];
      chk(srcStep[8*c+:8], v[11:8] == 4'h3 ? 8'h00 : stp(v[13:12], d[1:0]));
      chk(dstStep[8*c+:8], v[11:8] == 4'h3 ? 8'h00 : stp(v[15:14], v[4:3]));
      chk(unitSize[2*c+:2], v[4:3]);
      chk(burstMode[c], v[5]);
    end
    $display("random config done");
    masterEnable <= 1'h1;
    // bit0 cycle select, bit1 polarity, bit2 single mode, bit3 write cycle
    for (n = 0; n < 16; n++)
    begin
      wr(12'h000, 32'(n[0]) << 17 | 32'(n[1]) << 16 | (n[2] ? 32'h201 : 32'h1), r);
      readCycle[0] <= !n[3];
      writeCycle[0] <= n[3];
      tick(2);
      chk(transferAckOut[0], (n[2] || n[0] == n[3]) ^ n[1]);
    end
    readCycle <= 4'h0;
    writeCycle <= 4'h0;
    $display("ack done");
    wr(12'h008, 32'h1, r);
    // bit0 falling edge sampling, bit1 notice active low
    for (n = 0; n < 4; n++)
    begin
      wr(12'h000, 32'(n[0]) << 6 | 32'(n[1]) << 18 | 32'h1, r);
      takenLow <= {1'h0, n[1]};
      tick(1);
      chk(requestTakenOut[0], n[1]);
      want[0] <= 1'h1;
      do @(posedge clk); while (!channelRequest[0]);
      do @(posedge clk); while (requestTakenOut[0] !== !n[1]);
      chk(channelRequest[2], 1'h0);
      want[0] <= 1'h0;
      tick(6);
      chk(channelRequest[0], n[0]);
      pulse(4'h1, 1'h0);
      tick(3);
      chk(channelRequest[0], 1'h0);
    end
    $display("external request done");
    for (n = 0; n < 10; n++)
    begin
      v = 32'(n + 6) << 8;
      wr(12'h004, v, r);
      fire(4'(n + 6));
      wr(12'h004, v | 32'h1, r);
      tick(3);
      chk(channelRequest[1], 1'h0);
      fire(4'(n + 6));
      tick(4);
      chk(channelRequest[1], 1'h1);
      pulse(4'h2, 1'h0);
    end
    $display("peripheral done");
    wr(12'h008, 32'h405, r);
    tick(3);
    chk(channelRequest[2] & transferEnabled[2], 1'h1);
    pulse(4'h4, 1'h0);
    tick(1);
    pulse(4'h4, 1'h0);
    pulse(4'h4, 1'h1);
    tick(3);
    chk(decs, 3);
    chk({completionIrq[2], transferEnabled[2], channelRequest[2]}, 3'h4);
    wr(12'h008, 32'h405, r);
    rchk(2, 32'h407);
    // lane 0 off: the flag must survive a 0 write, upper lanes still land
    s_axi_wstrb <= 4'hE;
    wr(12'h008, 32'h0, r);
    s_axi_wstrb <= 4'hF;
    rchk(2, 32'h007);
    wr(12'h008, 32'h401, r);
    rchk(2, 32'h401);
    chk(completionIrq[2], 1'h0);
    pulse(4'h4, 1'h1);
    tick(3);
    chk(completionIrq[2], 1'h0);
    rchk(2, 32'h403);
    $display("completion done");
    // NMI, address error, master off, channel enable off
    for (n = 0; n < 4; n++)
    begin
      wr(12'h00C, 32'h401, r);
      tick(2);
      nmiSeenFlag <= n == 0;
      addressErrorFlag <= n == 1;
      masterEnable <= n != 2;
      if (n == 3)
        wr(12'h00C, 32'h400, r);
      tick(2);
      chk(transferEnabled[3], 1'h0);
      pulse(4'h8, 1'h1);
      tick(2);
      rchk(3, n == 3 ? 32'h400 : 32'h401);
      nmiSeenFlag <= 1'h0;
      addressErrorFlag <= 1'h0;
      masterEnable <= 1'h1;
    end
    $display("early stop done");
    standby <= 1'h1;
    tick(1);
    standby <= 1'h0;
    rchk(2, DCC_CTRL_RESET);
    $display("standby done");
    close_out;
  end

  // the whole run needs well under a third of this span
  initial
  begin
    tick(30000);
    failures++;
    close_out;
  end
endmodule

// ---- rtl/dcc_channel_control.sv ----
`timescale 1ns/1ps

// Function
// (RULE1) request-taken output of ch0/1: high active if level field 0, low if 1
// (RULE2) dual mode: ack on read or write cycle by mode field; single mode always
// (RULE3) ack, polarity, notify level, sampling fields only on ch0/1; else read 0
// (RULE4) ack output of ch0/1 high active if polarity field 0, low if 1
// (RULE5) destination step: fixed, increment or decrement by unit size; 11 prohibited
// (RULE6) source step: fixed, increment or decrement by unit size; 11 prohibited
// (RULE7) both steps ignored for single mode device-to-memory transfers
// (RULE8) ch3 indirect: source pointer steps by 4 or 0 regardless of unit size; the code also steps by -4 for the decrement code
// (RULE9) request source codes: external dual, single both ways, auto; 1 and 5 prohibited
// (RULE10) codes 6..15 select timer, conversion and serial port events in order
// (RULE11) external request codes honoured only on channels 0 and 1
// (RULE12) external request sampled by low level or falling edge per sampling field
// (RULE13) bus mode field selects cycle steal or burst
// (RULE14) unit size field: byte, word, longword; 11 prohibited
// (RULE15) completion interrupt raised only when its enable field is 1
// (RULE16) transfer-end flag set when the programmed count completes
// (RULE17) early stop by NMI, address error or enable clear leaves flag at 0
// (RULE18) no transfers while the transfer-end flag is 1
// (RULE19) flag cleared only by 0 write after reading 1, reset or standby
// (RULE20) auto-request starts at enable; other sources wait for a later request
// (RULE21) clearing channel enable suspends the transfer
// (RULE22) not enabled while flag set, master off, NMI or address error
// (RULE23) enabled only with both master enable and channel enable
// (RULE24) each finished unit decrements the count; count reaching zero ends it
// (RULE25) same logic for all four channels, missing fields read zero
module dcc_channel_control
  import dcc_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby,
  input wire logic masterEnable,
  input wire logic nmiSeenFlag,
  input wire logic addressErrorFlag,
  input wire logic [DCC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [DCC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] transferRequestIn_n,
  input wire logic [DCC_NUM_PERIPH-1:0] periphEvent,
  input wire logic [NUM_CH-1:0] unitDone,
  input wire logic [NUM_CH-1:0] countLast,
  input wire logic [NUM_CH-1:0] readCycle,
  input wire logic [NUM_CH-1:0] writeCycle,
  output logic [NUM_CH-1:0] transferEnabled,
  output logic [NUM_CH-1:0] channelRequest,
  output logic [NUM_CH-1:0] countDecrement,
  output logic [NUM_CH-1:0] completionIrq,
  output logic [NUM_CH-1:0] burstMode,
  output logic [2*NUM_CH-1:0] unitSize,
  output logic [8*NUM_CH-1:0] srcStep,
  output logic [8*NUM_CH-1:0] dstStep,
  output logic srcReload,
  output logic [1:0] transferAckOut,
  output logic [1:0] requestTakenOut
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic teArmed;
    logic pend;
    logic enabled;
    logic req;
    logic dec;
    logic irq;
    logic [7:0] sStep;
    logic [7:0] dStep;
  } dcc_chan_t;

  typedef struct packed {
    dcc_chan_t [NUM_CH-1:0] ch;
    logic [1:0] reqSync1;
    logic [1:0] reqSync2;
    logic [1:0] reqPrev;
    logic [1:0] ack;
    logic [1:0] taken;
    logic awSeen;
    logic [DCC_ADDR_W-1:0] awAddr;
    logic wSeen;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } dcc_state_t;

  dcc_state_t s_q;
  dcc_state_t s_d;

  // writable bits per channel; absent fields stay zero
  function automatic logic [31:0] chanMask(input int c);
    logic [31:0] m;
    m = DCC_MASK_COMMON;
    if (c < 2)
    begin
      m = m | DCC_MASK_EXT; // RULE3
    end
    if (c == 2)
    begin
      m = m | DCC_MASK_CH2;
    end
    if (c == 3)
    begin
      m = m | DCC_MASK_CH3;
    end
    return m;
  endfunction

  // register index of an address, all ones when unmapped
  function automatic logic [2:0] regIndex(input logic [DCC_ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a[1:0] == 2'h0 && a <= DCC_OFF_LAST)
    begin
      r = {1'b0, a[3:2]};
    end
    return r;
  endfunction

  // signed address delta for a step code and unit size
  function automatic logic [7:0] stepDelta(input logic [1:0] mode, input logic [1:0] size);
    logic [7:0] n;
    logic [7:0] r;
    case (size)
      DCC_SIZE_BYTE: n = DCC_DELTA_BYTE; // RULE14
      DCC_SIZE_WORD: n = DCC_DELTA_WORD;
      DCC_SIZE_LONG: n = DCC_DELTA_LONG;
      default: n = 8'h00; // prohibited size moves nothing
    endcase
    case (mode)
      DCC_STEP_INC: r = n;
      DCC_STEP_DEC: r = 8'h00 - n;
      default: r = 8'h00; // fixed, and the prohibited code
    endcase
    return r;
  endfunction

  // whole next state in one process
  always_comb
  begin
    logic [2:0] wIdx;
    logic [2:0] rIdx;
    logic doWrite;
    logic [31:0] laneMask;
    logic [31:0] wm;
    logic [31:0] cv;
    logic [3:0] rs;
    logic [3:0] pIdx;
    logic [3:0] extLow;
    logic [3:0] extFall;
    logic en;
    logic isExt;
    logic isSingle;
    logic isPeriph;
    logic evNow;
    logic lvlReq;
    logic clrTe;
    logic setTe;
    logic ackNow;
    s_d = s_q;
    wIdx = regIndex(s_q.awAddr);
    rIdx = regIndex(s_axi_araddr);
    doWrite = s_q.awSeen && s_q.wSeen && !s_q.bValid;
    laneMask = {{8{s_q.wStrb[3]}}, {8{s_q.wStrb[2]}}, {8{s_q.wStrb[1]}}, {8{s_q.wStrb[0]}}};
    wm = 32'h00000000;
    cv = 32'h00000000;
    rs = 4'h0;
    pIdx = 4'h0;
    en = 1'b0;
    isExt = 1'b0;
    isSingle = 1'b0;
    isPeriph = 1'b0;
    evNow = 1'b0;
    lvlReq = 1'b0;
    clrTe = 1'b0;
    setTe = 1'b0;
    ackNow = 1'b0;

    // request pins: two flops, then a third stage for the edge
    s_d.reqSync1 = transferRequestIn_n;
    s_d.reqSync2 = s_q.reqSync1;
    s_d.reqPrev = s_q.reqSync2;
    extLow = {2'b00, ~s_q.reqSync2};
    extFall = {2'b00, ~s_q.reqSync2 & s_q.reqPrev};

    // write channels: address and data taken in either order
    if (s_axi_awvalid && !s_q.awSeen && !s_q.bValid)
    begin
      s_d.awSeen = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wSeen && !s_q.bValid)
    begin
      s_d.wSeen = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (doWrite)
    begin
      s_d.awSeen = 1'b0;
      s_d.wSeen = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = (wIdx[2]) ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
    end
    else if (s_q.bValid && s_axi_bready)
    begin
      s_d.bValid = 1'b0;
    end

    // read channel: data one cycle after the address is taken
    if (s_axi_arvalid && !s_q.rValid)
    begin
      s_d.rValid = 1'b1;
      s_d.rData = 32'h00000000;
      s_d.rResp = (rIdx[2]) ? DCC_RESP_SLVERR : DCC_RESP_OKAY;
    end
    else if (s_q.rValid && s_axi_rready)
    begin
      s_d.rValid = 1'b0;
    end

    for (int c = 0; c < NUM_CH; c++)
    begin
      cv = s_q.ch[c].ctrl;

      // software write through byte lanes and the channel's field mask
      clrTe = 1'b0;
      if (doWrite && wIdx == 3'(c))
      begin
        wm = chanMask(c) & laneMask;
        s_d.ch[c].ctrl = (cv & ~wm) | (s_q.wData & wm); // RULE3 RULE25
        clrTe = s_q.ch[c].teArmed && s_q.wStrb[0] && !s_q.wData[DCC_BIT_TE]; // RULE19
        s_d.ch[c].teArmed = 1'b0;
      end

      // a read that sees the flag set arms the next 0 write; it beats a same-cycle disarm
      if (s_axi_arvalid && !s_q.rValid && rIdx == 3'(c))
      begin
        s_d.rData = cv;
        if (cv[DCC_BIT_TE])
        begin
          s_d.ch[c].teArmed = 1'b1; // RULE19
        end
      end
      // enable gate from the current settings
      en = cv[DCC_BIT_DE] && !cv[DCC_BIT_TE] && masterEnable // RULE18 RULE23
        && !nmiSeenFlag && !addressErrorFlag; // RULE22
      rs = cv[DCC_BIT_RS +: 4];
      isExt = (c < 2) && (rs == DCC_RS_EXT_DUAL || rs == DCC_RS_EXT_TO_DEV // RULE9 RULE11
        || rs == DCC_RS_DEV_TO_MEM);
      isSingle = isExt && (rs != DCC_RS_EXT_DUAL);
      isPeriph = (rs >= DCC_RS_PERIPH0); // RULE10
      pIdx = rs - DCC_RS_PERIPH0;

      // edge-type events are held until a unit finishes
      if (isPeriph)
      begin
        evNow = periphEvent[pIdx]; // RULE10
      end
      else
      begin
        evNow = isExt && cv[DCC_BIT_DS] && extFall[c]; // RULE12
      end
      lvlReq = isExt && !cv[DCC_BIT_DS] && extLow[c]; // RULE12

      // a request seen before enable is dropped, so only later ones count
      if (!en)
      begin
        s_d.ch[c].pend = 1'b0; // RULE20 RULE21
      end
      else if (evNow)
      begin
        s_d.ch[c].pend = 1'b1;
      end
      else if (unitDone[c])
      begin
        s_d.ch[c].pend = 1'b0;
      end
      s_d.ch[c].enabled = en;
      s_d.ch[c].req = en && ((rs == DCC_RS_AUTO) || s_q.ch[c].pend || lvlReq); // RULE20

      // completion: only a normal end reaches the flag; set beats clear
      setTe = en && unitDone[c] && countLast[c]; // RULE16 RULE17 RULE24
      if (setTe)
      begin
        s_d.ch[c].ctrl[DCC_BIT_TE] = 1'b1; // RULE16
      end
      else if (clrTe)
      begin
        s_d.ch[c].ctrl[DCC_BIT_TE] = 1'b0; // RULE19
      end
      s_d.ch[c].dec = en && unitDone[c]; // RULE24
      s_d.ch[c].irq = s_d.ch[c].ctrl[DCC_BIT_TE] && cv[DCC_BIT_IE]; // RULE15

      // address steps for the sequencer
      if (isExt && rs == DCC_RS_DEV_TO_MEM)
      begin
        s_d.ch[c].sStep = 8'h00; // RULE7
        s_d.ch[c].dStep = 8'h00; // RULE7
      end
      else
      begin
        s_d.ch[c].dStep = stepDelta(cv[DCC_BIT_DM +: 2], cv[DCC_BIT_TS +: 2]); // RULE5
        if (cv[DCC_BIT_DI])
        begin
          s_d.ch[c].sStep = stepDelta(cv[DCC_BIT_SM +: 2], DCC_SIZE_LONG); // RULE8
        end
        else
        begin
          s_d.ch[c].sStep = stepDelta(cv[DCC_BIT_SM +: 2], cv[DCC_BIT_TS +: 2]); // RULE6
        end
      end

      // pin outputs of the external channels, polarity applied last
      if (c < 2)
      begin
        if (isSingle)
        begin
          ackNow = en && (readCycle[c] || writeCycle[c]); // RULE2
        end
        else if (cv[DCC_BIT_AM])
        begin
          ackNow = en && isExt && writeCycle[c]; // RULE2
        end
        else
        begin
          ackNow = en && isExt && readCycle[c]; // RULE2
        end
        s_d.ack[c[0]] = ackNow ^ cv[DCC_BIT_AL]; // RULE4
        s_d.taken[c[0]] = (en && (evNow || lvlReq)) ^ cv[DCC_BIT_RL]; // RULE1
      end
    end
  end

  // single register stage; standby clears like power-on
  always_ff @(posedge clk)
  begin
    if (!nrst || standby)
    begin
      s_q <= '0; // RULE19
      {s_q.reqSync1, s_q.reqSync2, s_q.reqPrev} <= 6'h3F; // pins idle high: no false request
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ready outputs are combinational, valid and data outputs registered
  assign s_axi_awready = !s_q.awSeen && !s_q.bValid;
  assign s_axi_wready = !s_q.wSeen && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign transferAckOut = s_q.ack;
  assign requestTakenOut = s_q.taken;
  assign srcReload = s_q.ch[2].ctrl[DCC_BIT_RO];

  // per-channel outputs
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : gCh
      assign transferEnabled[g] = s_q.ch[g].enabled;
      assign channelRequest[g] = s_q.ch[g].req;
      assign countDecrement[g] = s_q.ch[g].dec;
      assign completionIrq[g] = s_q.ch[g].irq;
      assign burstMode[g] = s_q.ch[g].ctrl[DCC_BIT_TM]; // RULE13
      assign unitSize[2*g +: 2] = s_q.ch[g].ctrl[DCC_BIT_TS +: 2]; // RULE14
      assign srcStep[8*g +: 8] = s_q.ch[g].sStep;
      assign dstStep[8*g +: 8] = s_q.ch[g].dStep;
    end
  endgenerate

endmodule

// ---- rtl/dcc_pkg.sv ----
package dcc_pkg;

  // register map, byte addresses on the AXI4-Lite port
  localparam int DCC_ADDR_W = 12;
  localparam logic [11:0] DCC_OFF_CH0 = 12'h000;
  localparam logic [11:0] DCC_OFF_CH1 = 12'h004;
  localparam logic [11:0] DCC_OFF_CH2 = 12'h008;
  localparam logic [11:0] DCC_OFF_CH3 = 12'h00C;
  localparam logic [11:0] DCC_OFF_LAST = DCC_OFF_CH3;
  localparam logic [31:0] DCC_CTRL_RESET = 32'h00000000;

  // field positions in a channel control register
  localparam int DCC_BIT_DE = 0;
  localparam int DCC_BIT_TE = 1;
  localparam int DCC_BIT_IE = 2;
  localparam int DCC_BIT_TS = 3;
  localparam int DCC_BIT_TM = 5;
  localparam int DCC_BIT_DS = 6;
  localparam int DCC_BIT_RS = 8;
  localparam int DCC_BIT_SM = 12;
  localparam int DCC_BIT_DM = 14;
  localparam int DCC_BIT_AL = 16;
  localparam int DCC_BIT_AM = 17;
  localparam int DCC_BIT_RL = 18;
  localparam int DCC_BIT_RO = 19;
  localparam int DCC_BIT_DI = 20;

  // writable bits; the flag bit is handled apart
  localparam logic [31:0] DCC_MASK_COMMON = 32'h0000FF3D;
  localparam logic [31:0] DCC_MASK_EXT = 32'h00070040;
  localparam logic [31:0] DCC_MASK_CH2 = 32'h00080000;
  localparam logic [31:0] DCC_MASK_CH3 = 32'h00100000;

  // request source codes
  localparam logic [3:0] DCC_RS_EXT_DUAL = 4'h0;
  localparam logic [3:0] DCC_RS_EXT_TO_DEV = 4'h2;
  localparam logic [3:0] DCC_RS_DEV_TO_MEM = 4'h3;
  localparam logic [3:0] DCC_RS_AUTO = 4'h4;
  localparam logic [3:0] DCC_RS_PERIPH0 = 4'h6;
  localparam int DCC_NUM_PERIPH = 10;

  // address step codes and sizes
  localparam logic [1:0] DCC_STEP_FIXED = 2'h0;
  localparam logic [1:0] DCC_STEP_INC = 2'h1;
  localparam logic [1:0] DCC_STEP_DEC = 2'h2;
  localparam logic [1:0] DCC_SIZE_BYTE = 2'h0;
  localparam logic [1:0] DCC_SIZE_WORD = 2'h1;
  localparam logic [1:0] DCC_SIZE_LONG = 2'h2;
  localparam logic [7:0] DCC_DELTA_BYTE = 8'h01;
  localparam logic [7:0] DCC_DELTA_WORD = 8'h02;
  localparam logic [7:0] DCC_DELTA_LONG = 8'h04;

  // bus responses
  localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

endpackage
